// >>> verilog/cmpref_top.sv
// Comparator and reference control with Avalon-MM register slave
//
// Behaviour
// - Result bit in comparator control is read-only; writes do not change it.
// - Three modes drive the result to the output pin without resynchronising.
// - In output modes a cleared direction bit 2 enables the pin output.
// - Port value reads return zero for pins configured as analog.
// - Reference offers 32 settings: 4-bit level in a low and high range.
// - Range 1: level/24 of supply; range 0: quarter plus level/32.
// - Reference enable bit 7 powers the ladder; cleared means fully off.
// - Comparator and reference keep running while the device sleeps.
// - Comparator event wakes from sleep; control registers stay unchanged.
// - Reset gives mode 000 and reference off, all inputs analog.
// - Change flag sets while the result differs from the latched value.
// - Flag clears only by writing 0; writing 1 sets it.
// - Request needs change, peripheral and global enables; flag sets regardless.
// - Mismatch keeps setting the flag until a control access updates latch.
// - A result change coinciding with a control read may miss the flag.
// - Reset values: control -0-0 0000, reference 0-0- 0000, gaps read zero.
// - Invert bit 4 inverts the reported result.
// - In modes 110 and 101 the switch bit selects the inverting input pin.
`timescale 1ns/1ps
`default_nettype none
module cmpref_top
   import cmpref_pkg::*;
#(
   parameter int PORT_PINS = 6
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic comp_raw,
   input wire logic [5:0] port_in,
   input wire logic sleep_mode,
   output logic comp_enable,
   output logic vin_minus_switch,
   output logic ref_to_input,
   output logic reference_enable,
   output logic reference_range,
   output logic [3:0] reference_level,
   output logic [6:0] reference_tap,
   output logic [1:0] analog_pins,
   output logic comparator_out_pin,
   output logic comparator_out_pin_oe,
   output logic comparator_irq,
   output logic wake_request
);
   if (PORT_PINS != 6)
   begin : g_bad_pins
      $error("PORT_PINS must be 6");
   end

   // Register index helper
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] idx);
      hit = (addr == idx);
   endfunction : hit

   // Bus handshake
   cmpref_bus_e bus_state;
   cmpref_bus_e next_bus_state;
   logic next_waitrequest;
   logic [31:0] next_readdata;
   logic take;
   logic [7:0] rd_byte;

   // Accepted at the edge where waitrequest is sampled low
   assign take = (avs_read | avs_write) & ~avs_waitrequest;

   // Register state
   logic global_int_enable;
   logic peripheral_int_enable;
   logic comparator_change_flag;
   logic comparator_change_enable;
   logic [2:0] comparator_mode_field;
   logic input_switch;
   logic output_invert;
   logic [5:0] pin_direction_reg;
   logic ref_en_q;
   logic ref_range_q;
   logic [3:0] ref_level_q;
   logic comparator_result;
   logic result_latch;

   logic next_global_int_enable;
   logic next_peripheral_int_enable;
   logic next_comparator_change_flag;
   logic next_comparator_change_enable;
   logic [2:0] next_comparator_mode_field;
   logic next_input_switch;
   logic next_output_invert;
   logic [5:0] next_pin_direction_reg;
   logic next_ref_en_q;
   logic next_ref_range_q;
   logic [3:0] next_ref_level_q;
   logic next_comparator_result;
   logic next_result_latch;

   // Mode decode
   logic dec_comp_on;
   logic dec_ref_used;
   logic dec_out_pin;
   logic dec_switch;
   logic [1:0] dec_analog;

   cmpref_mode_decode u_decode (
      .mode(comparator_mode_field),
      .input_switch(input_switch),
      .comp_on(dec_comp_on),
      .ref_used(dec_ref_used),
      .out_pin_mode(dec_out_pin),
      .vin_minus_switch(dec_switch),
      .analog_pins(dec_analog)
   );

   cmpref_ref_ladder u_ladder (
      .core_clk(core_clk),
      .nrst(nrst),
      .enable(ref_en_q),
      .range_low(ref_range_q),
      .level(ref_level_q),
      .tap(reference_tap)
   );

   logic wr_lane;
   logic [7:0] wdat;
   logic cmp_access;
   logic mismatch;

   assign wr_lane = take & avs_write & avs_byteenable[0];
   assign wdat = avs_writedata[7:0];
   assign cmp_access = take & hit(avs_address, CMPREF_IDX_CMP_CTRL);
   assign mismatch = comparator_result ^ result_latch;

   // Read mux, unmapped and reserved bits read zero
   always_comb
   begin
      rd_byte = 8'h00;
      if (hit(avs_address, CMPREF_IDX_INT_CTRL) ||
          hit(avs_address, CMPREF_IDX_INT_CTRL_ALT))
      begin
         rd_byte[CMPREF_GLOBAL_IE_BIT] = global_int_enable;
         rd_byte[CMPREF_PERIPH_IE_BIT] = peripheral_int_enable;
      end
      else if (hit(avs_address, CMPREF_IDX_PERIPH_FLAGS))
         rd_byte[CMPREF_CHG_BIT] = comparator_change_flag;
      else if (hit(avs_address, CMPREF_IDX_PERIPH_EN))
         rd_byte[CMPREF_CHG_BIT] = comparator_change_enable;
      else if (hit(avs_address, CMPREF_IDX_CMP_CTRL))
      begin
         rd_byte[CMPREF_RESULT_BIT] = comparator_result;
         rd_byte[CMPREF_INVERT_BIT] = output_invert;
         rd_byte[CMPREF_SWITCH_BIT] = input_switch;
         rd_byte[CMPREF_MODE_LSB +: 3] = comparator_mode_field;
      end
      else if (hit(avs_address, CMPREF_IDX_PIN_DIR))
         rd_byte[5:0] = pin_direction_reg;
      else if (hit(avs_address, CMPREF_IDX_REF_CTRL))
      begin
         rd_byte[CMPREF_REF_EN_BIT] = ref_en_q;
         rd_byte[CMPREF_RANGE_BIT] = ref_range_q;
         rd_byte[CMPREF_LEVEL_LSB +: 4] = ref_level_q;
      end
      else if (hit(avs_address, CMPREF_IDX_PORT_VALUE))
         rd_byte[5:0] = port_in & ~{4'h0, analog_pins};
   end

   // Answer one cycle after the request appears, then release
   always_comb
   begin
      next_bus_state = bus_state;
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      unique case (bus_state)
         CMPREF_BUS_IDLE:
            if (avs_read | avs_write)
            begin
               next_bus_state = CMPREF_BUS_DONE;
               next_waitrequest = 1'b0;
               next_readdata = {24'h000000, rd_byte};
            end
         CMPREF_BUS_DONE:
         begin
            next_bus_state = CMPREF_BUS_IDLE;
            next_readdata = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_state <= CMPREF_BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         bus_state <= next_bus_state;
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
      end
   end

   // Register updates
   // Sleep has no effect on any of this state
   always_comb
   begin
      next_global_int_enable = global_int_enable;
      next_peripheral_int_enable = peripheral_int_enable;
      next_comparator_change_enable = comparator_change_enable;
      next_comparator_mode_field = comparator_mode_field;
      next_input_switch = input_switch;
      next_output_invert = output_invert;
      next_pin_direction_reg = pin_direction_reg;
      next_ref_en_q = ref_en_q;
      next_ref_range_q = ref_range_q;
      next_ref_level_q = ref_level_q;
      next_comparator_change_flag = comparator_change_flag;
      if (wr_lane)
      begin
         if (hit(avs_address, CMPREF_IDX_INT_CTRL) ||
             hit(avs_address, CMPREF_IDX_INT_CTRL_ALT))
         begin
            next_global_int_enable = wdat[CMPREF_GLOBAL_IE_BIT];
            next_peripheral_int_enable = wdat[CMPREF_PERIPH_IE_BIT];
         end
         if (hit(avs_address, CMPREF_IDX_PERIPH_EN))
            next_comparator_change_enable = wdat[CMPREF_CHG_BIT];
         if (hit(avs_address, CMPREF_IDX_CMP_CTRL))
         begin
            // Result bit position is not writable
            next_output_invert = wdat[CMPREF_INVERT_BIT];
            next_input_switch = wdat[CMPREF_SWITCH_BIT];
            next_comparator_mode_field = wdat[CMPREF_MODE_LSB +: 3];
         end
         if (hit(avs_address, CMPREF_IDX_PIN_DIR))
            next_pin_direction_reg = wdat[5:0];
         if (hit(avs_address, CMPREF_IDX_REF_CTRL))
         begin
            next_ref_en_q = wdat[CMPREF_REF_EN_BIT];
            next_ref_range_q = wdat[CMPREF_RANGE_BIT];
            next_ref_level_q = wdat[CMPREF_LEVEL_LSB +: 4];
         end
         if (hit(avs_address, CMPREF_IDX_PERIPH_FLAGS))
            next_comparator_change_flag = wdat[CMPREF_CHG_BIT];
      end
      // Hardware set wins over a software clear
      if (mismatch)
         next_comparator_change_flag = 1'b1;
   end

   // Result and its latch
   always_comb
   begin
      next_comparator_result = 1'b0;
      if (dec_comp_on)
         next_comparator_result = comp_raw ^ output_invert;
      next_result_latch = result_latch;
      // Latch takes the fresh result; a change on this edge goes unseen
      if (cmp_access)
         next_result_latch = next_comparator_result;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         global_int_enable <= CMPREF_RST_INT_CTRL[CMPREF_GLOBAL_IE_BIT];
         peripheral_int_enable <= CMPREF_RST_INT_CTRL[CMPREF_PERIPH_IE_BIT];
         comparator_change_flag <= CMPREF_RST_PERIPH_FLAGS[CMPREF_CHG_BIT];
         comparator_change_enable <= CMPREF_RST_PERIPH_EN[CMPREF_CHG_BIT];
         comparator_mode_field <= CMPREF_RST_CMP_CTRL[2:0];
         input_switch <= CMPREF_RST_CMP_CTRL[CMPREF_SWITCH_BIT];
         output_invert <= CMPREF_RST_CMP_CTRL[CMPREF_INVERT_BIT];
         pin_direction_reg <= CMPREF_RST_PIN_DIR;
         ref_en_q <= CMPREF_RST_REF_CTRL[CMPREF_REF_EN_BIT];
         ref_range_q <= CMPREF_RST_REF_CTRL[CMPREF_RANGE_BIT];
         ref_level_q <= CMPREF_RST_REF_CTRL[3:0];
         comparator_result <= 1'b0;
         result_latch <= 1'b0;
      end
      else
      begin
         global_int_enable <= next_global_int_enable;
         peripheral_int_enable <= next_peripheral_int_enable;
         comparator_change_flag <= next_comparator_change_flag;
         comparator_change_enable <= next_comparator_change_enable;
         comparator_mode_field <= next_comparator_mode_field;
         input_switch <= next_input_switch;
         output_invert <= next_output_invert;
         pin_direction_reg <= next_pin_direction_reg;
         ref_en_q <= next_ref_en_q;
         ref_range_q <= next_ref_range_q;
         ref_level_q <= next_ref_level_q;
         comparator_result <= next_comparator_result;
         result_latch <= next_result_latch;
      end
   end

   // Analog-side and pin outputs
   logic next_comp_enable;
   logic next_vin_minus_switch;
   logic next_ref_to_input;
   logic [1:0] next_analog_pins;
   logic next_out_pin;
   logic next_out_pin_oe;
   logic next_irq;
   logic next_wake;

   always_comb
   begin
      next_comp_enable = dec_comp_on;
      next_vin_minus_switch = dec_switch;
      next_ref_to_input = dec_ref_used;
      next_analog_pins = dec_analog;
      // Raw decision with inversion, no two-stage resynchroniser
      next_out_pin = dec_comp_on & (comp_raw ^ output_invert);
      next_out_pin_oe = dec_out_pin &
                        ~pin_direction_reg[CMPREF_OUT_PIN];
      next_irq = comparator_change_flag & comparator_change_enable &
                 peripheral_int_enable & global_int_enable;
      next_wake = sleep_mode & dec_comp_on & comparator_change_flag &
                  comparator_change_enable;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         comp_enable <= 1'b0;
         vin_minus_switch <= 1'b0;
         ref_to_input <= 1'b0;
         analog_pins <= 2'h3;
         comparator_out_pin <= 1'b0;
         comparator_out_pin_oe <= 1'b0;
         comparator_irq <= 1'b0;
         wake_request <= 1'b0;
      end
      else
      begin
         comp_enable <= next_comp_enable;
         vin_minus_switch <= next_vin_minus_switch;
         ref_to_input <= next_ref_to_input;
         analog_pins <= next_analog_pins;
         comparator_out_pin <= next_out_pin;
         comparator_out_pin_oe <= next_out_pin_oe;
         comparator_irq <= next_irq;
         wake_request <= next_wake;
      end
   end

   // Reference controls mirrored to the analog ladder
   assign reference_enable = ref_en_q;
   assign reference_range = ref_range_q;
   assign reference_level = ref_level_q;

endmodule : cmpref_top
`default_nettype wire

// >>> verilog/cmpref_pkg.sv
// Constants shared by the comparator and reference control block
package cmpref_pkg;
   // Register word indices; byte address is four times the index
   localparam logic [7:0] CMPREF_IDX_PORT_VALUE = 8'h05;
   localparam logic [7:0] CMPREF_IDX_INT_CTRL = 8'h0b;
   localparam logic [7:0] CMPREF_IDX_INT_CTRL_ALT = 8'h8b;
   localparam logic [7:0] CMPREF_IDX_PERIPH_FLAGS = 8'h0c;
   localparam logic [7:0] CMPREF_IDX_CMP_CTRL = 8'h19;
   localparam logic [7:0] CMPREF_IDX_PIN_DIR = 8'h85;
   localparam logic [7:0] CMPREF_IDX_PERIPH_EN = 8'h8c;
   localparam logic [7:0] CMPREF_IDX_REF_CTRL = 8'h99;
   // Field positions
   localparam int CMPREF_GLOBAL_IE_BIT = 7;
   localparam int CMPREF_PERIPH_IE_BIT = 6;
   localparam int CMPREF_CHG_BIT = 3;
   localparam int CMPREF_RESULT_BIT = 6;
   localparam int CMPREF_INVERT_BIT = 4;
   localparam int CMPREF_SWITCH_BIT = 3;
   localparam int CMPREF_MODE_LSB = 0;
   localparam int CMPREF_REF_EN_BIT = 7;
   localparam int CMPREF_RANGE_BIT = 5;
   localparam int CMPREF_LEVEL_LSB = 0;
   localparam int CMPREF_OUT_PIN = 2;
   // Reset values
   localparam logic [7:0] CMPREF_RST_INT_CTRL = 8'h00;
   localparam logic [7:0] CMPREF_RST_PERIPH_FLAGS = 8'h00;
   localparam logic [7:0] CMPREF_RST_CMP_CTRL = 8'h00;
   localparam logic [5:0] CMPREF_RST_PIN_DIR = 6'h3f;
   localparam logic [7:0] CMPREF_RST_PERIPH_EN = 8'h00;
   localparam logic [7:0] CMPREF_RST_REF_CTRL = 8'h00;
   // Comparator mode codes
   localparam logic [2:0] CMPREF_MODE_RESET = 3'h0;
   localparam logic [2:0] CMPREF_MODE_OUT_DIRECT = 3'h1;
   localparam logic [2:0] CMPREF_MODE_OUT_REF = 3'h2;
   localparam logic [2:0] CMPREF_MODE_DIRECT = 3'h3;
   localparam logic [2:0] CMPREF_MODE_REF = 3'h4;
   localparam logic [2:0] CMPREF_MODE_SW_REF = 3'h5;
   localparam logic [2:0] CMPREF_MODE_SW_OUT_REF = 3'h6;
   localparam logic [2:0] CMPREF_MODE_OFF = 3'h7;
   // Reference ladder in ninety-sixths of supply
   localparam logic [6:0] CMPREF_LOW_STEP = 7'h04;
   localparam logic [6:0] CMPREF_HIGH_STEP = 7'h03;
   localparam logic [6:0] CMPREF_HIGH_BASE = 7'h18;
   // Bus handshake states
   typedef enum logic [0:0] {CMPREF_BUS_IDLE, CMPREF_BUS_DONE} cmpref_bus_e;
endpackage : cmpref_pkg

// >>> verilog/cmpref_mode_decode.sv
// Decode of the comparator mode field into routing controls
`timescale 1ns/1ps
`default_nettype none
module cmpref_mode_decode
   import cmpref_pkg::*;
(
   input wire logic [2:0] mode,
   input wire logic input_switch,
   output logic comp_on,
   output logic ref_used,
   output logic out_pin_mode,
   output logic vin_minus_switch,
   output logic [1:0] analog_pins
);
   always_comb
   begin
      comp_on = 1'b1;
      ref_used = 1'b0;
      out_pin_mode = 1'b0;
      vin_minus_switch = 1'b0;
      analog_pins = 2'h3;
      unique case (mode)
         CMPREF_MODE_RESET: comp_on = 1'b0;
         CMPREF_MODE_OUT_DIRECT: out_pin_mode = 1'b1;
         CMPREF_MODE_OUT_REF:
         begin
            ref_used = 1'b1;
            out_pin_mode = 1'b1;
         end
         CMPREF_MODE_DIRECT: ;
         CMPREF_MODE_REF: ref_used = 1'b1;
         CMPREF_MODE_SW_REF:
         begin
            ref_used = 1'b1;
            vin_minus_switch = input_switch;
         end
         CMPREF_MODE_SW_OUT_REF:
         begin
            ref_used = 1'b1;
            out_pin_mode = 1'b1;
            vin_minus_switch = input_switch;
         end
         CMPREF_MODE_OFF:
         begin
            comp_on = 1'b0;
            analog_pins = 2'h0;
         end
      endcase
   end
endmodule : cmpref_mode_decode
`default_nettype wire

// >>> verilog/cmpref_ref_ladder.sv
// Reference ladder tap selection in ninety-sixths of supply
`timescale 1ns/1ps
`default_nettype none
module cmpref_ref_ladder
   import cmpref_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic range_low,
   input wire logic [3:0] level,
   output logic [6:0] tap
);
   logic [6:0] next_tap;
   // Low: level/24 = 4*level/96; high: 1/4 + level/32 = (24+3*level)/96
   always_comb
   begin
      next_tap = 7'h00;
      if (enable)
      begin
         if (range_low)
            next_tap = 7'({3'h0, level}) * CMPREF_LOW_STEP;
         else
            next_tap = CMPREF_HIGH_BASE + 7'({3'h0, level}) * CMPREF_HIGH_STEP;
      end
   end
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         tap <= 7'h00;
      else
         tap <= next_tap;
   end
endmodule : cmpref_ref_ladder
`default_nettype wire

// >>> testbench/cmpref_top_asserts.sv
// Port-level checks for the comparator and reference block
`timescale 1ns/1ps
`default_nettype none
module cmpref_top_asserts
   import cmpref_pkg::*;
#(
   parameter int PORT_PINS = 6
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sleep_mode,
   input wire logic comp_enable,
   input wire logic vin_minus_switch,
   input wire logic ref_to_input,
   input wire logic reference_enable,
   input wire logic reference_range,
   input wire logic [3:0] reference_level,
   input wire logic [6:0] reference_tap,
   input wire logic [1:0] analog_pins,
   input wire logic comparator_out_pin_oe,
   input wire logic wake_request
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_pending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_pending |=> s_answer)
      else $error("bus request not answered for exactly one cycle");
   a_idle_data: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data not zero outside the answer cycle");
   a_tap_off: assert property (!$past(reference_enable) |->
      reference_tap == 7'h00)
      else $error("reference tap active while disabled");
   a_tap_low: assert property ($past(reference_enable) &&
      $past(reference_range) |->
      reference_tap == {1'b0, $past(reference_level), 2'b00})
      else $error("low range tap wrong");
   a_tap_high: assert property ($past(reference_enable) &&
      !$past(reference_range) |->
      reference_tap == 7'h18 + 7'($past(reference_level)) * 7'h03)
      else $error("high range tap wrong");
   a_off_pins: assert property (analog_pins == 2'b00 |-> !comp_enable)
      else $error("digital pins with comparator powered");
   a_oe_mode: assert property (comparator_out_pin_oe |-> comp_enable)
      else $error("output pin driven with comparator off");
   a_ref_mode: assert property (ref_to_input |-> comp_enable)
      else $error("reference routed with comparator off");
   a_switch_mode: assert property (vin_minus_switch |-> ref_to_input)
      else $error("input switch active outside switch modes");
   a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
      else $error("wake request while awake");
endmodule : cmpref_top_asserts
`default_nettype wire

// >>> testbench/test_cmpref_top.sv
// Register-level testbench for the comparator and reference block
`timescale 1ns/1ps
`default_nettype none
module test_cmpref_top;
   import cmpref_pkg::*;
   logic core_clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable, reference_level;
   logic comp_raw, sleep_mode, comp_enable, vin_minus_switch, ref_to_input;
   logic reference_enable, reference_range, comparator_out_pin;
   logic comparator_out_pin_oe, comparator_irq, wake_request;
   logic [5:0] port_in;
   logic [6:0] reference_tap;
   logic [1:0] analog_pins;
   int failures, check_count;
   logic [7:0] ridx [8] = '{8'h0b, 8'h8b, 8'h0c, 8'h19, 8'h85, 8'h8c, 8'h99,
      8'h40};
   logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00,
      8'h00};
   logic [7:0] swc [4] = '{8'h0d, 8'h0e, 8'h0b, 8'h05};
   cmpref_top #(.PORT_PINS(6)) dut (.core_clk(core_clk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .comp_raw(comp_raw), .port_in(port_in), .sleep_mode(sleep_mode),
      .comp_enable(comp_enable), .vin_minus_switch(vin_minus_switch),
      .ref_to_input(ref_to_input), .reference_enable(reference_enable),
      .reference_range(reference_range), .reference_level(reference_level),
      .reference_tap(reference_tap), .analog_pins(analog_pins),
      .comparator_out_pin(comparator_out_pin),
      .comparator_out_pin_oe(comparator_out_pin_oe),
      .comparator_irq(comparator_irq), .wake_request(wake_request));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx,
      input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= idx;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rdchk(input string name, input logic [7:0] idx,
      input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(name, rd, {24'h0, exp});
   endtask : rdchk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial
   begin
      #40000;
      failures++;
      end_of_test();
   end
   initial
   begin
      failures = 0;
      check_count = 0;
      nrst = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      comp_raw = 1'b0;
      port_in = 6'h3f;
      sleep_mode = 1'b0;
      cyc(16);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++)
         rdchk("reset value", ridx[i], rval[i]);
      rdchk("port value", 8'h05, 8'h3c);
      check("analog_pins", 32'(analog_pins), 32'h3);
      check("comp_enable", 32'(comp_enable), 32'h0);
      $display("reset test done");
      wr(8'h99, 8'hff);
      rdchk("reference control", 8'h99, 8'haf);
      for (int r = 0; r < 2; r++)
         for (int lv = 0; lv < 16; lv += 5)
         begin
            wr(8'h99, {2'b10, r[0], 1'b0, lv[3:0]});
            cyc(3);
            check("tap", 32'(reference_tap), r ? 4 * lv : 24 + 3 * lv);
         end
      wr(8'h99, 8'h2f);
      cyc(3);
      check("tap off", 32'(reference_tap), 32'h0);
      $display("reference test done");
      comp_raw <= 1'b1;
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h19, 8'(m));
         cyc(3);
         check("comp_enable", 32'(comp_enable), 32'(m != 0 && m != 7));
         check("ref_to_input", 32'(ref_to_input), 32'(m == 2 ||
            (m >= 4 && m <= 6)));
         check("analog_pins", 32'(analog_pins), m == 7 ? 0 : 3);
      end
      port_in <= 6'h2a;
      rdchk("port value", 8'h05, 8'h2a);
      comp_raw <= 1'b0;
      wr(8'h19, 8'h41);
      cyc(3);
      rdchk("result", 8'h19, 8'h01);
      comp_raw <= 1'b1;
      cyc(3);
      rdchk("result", 8'h19, 8'h41);
      wr(8'h19, 8'h51);
      cyc(3);
      rdchk("inverted", 8'h19, 8'h11);
      wr(8'h85, 8'h3b);
      cyc(3);
      check("oe", 32'(comparator_out_pin_oe), 32'h1);
      check("out pin", 32'(comparator_out_pin), 32'h0);
      comp_raw <= 1'b0;
      cyc(3);
      check("out pin", 32'(comparator_out_pin), 32'h1);
      wr(8'h85, 8'h3f);
      cyc(3);
      check("oe", 32'(comparator_out_pin_oe), 32'h0);
      wr(8'h85, 8'h3b);
      wr(8'h19, 8'h03);
      cyc(3);
      check("oe", 32'(comparator_out_pin_oe), 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h19, swc[i]);
         cyc(3);
         check("switch", 32'(vin_minus_switch), 32'(i < 2));
      end
      $display("mode test done");
      wr(8'h19, 8'h03);
      rdchk("result", 8'h19, 8'h03);
      wr(8'h0c, 8'h00);
      rdchk("flag", 8'h0c, 8'h00);
      comp_raw <= 1'b1;
      cyc(4);
      rdchk("flag", 8'h0c, 8'h08);
      wr(8'h0c, 8'h00);
      rdchk("flag", 8'h0c, 8'h08);
      rdchk("result", 8'h19, 8'h43);
      wr(8'h0c, 8'h00);
      rdchk("flag", 8'h0c, 8'h00);
      wr(8'h0b, 8'hc0);
      wr(8'h8c, 8'h08);
      cyc(3);
      check("irq", 32'(comparator_irq), 32'h0);
      wr(8'h0c, 8'h08);
      cyc(3);
      check("irq", 32'(comparator_irq), 32'h1);
      wr(8'h0b, 8'h40);
      cyc(3);
      check("irq", 32'(comparator_irq), 32'h0);
      rdchk("flag", 8'h0c, 8'h08);
      sleep_mode <= 1'b1;
      cyc(3);
      check("wake", 32'(wake_request), 32'h1);
      check("comp_enable", 32'(comp_enable), 32'h1);
      rdchk("asleep", 8'h19, 8'h43);
      rdchk("asleep", 8'h99, 8'h2f);
      sleep_mode <= 1'b0;
      avs_byteenable <= 4'h0;
      wr(8'h99, 8'hff);
      avs_byteenable <= 4'hf;
      rdchk("no byte enable", 8'h99, 8'h2f);
      $display("flag test done");
      nrst <= 1'b0;
      cyc(3);
      check("analog_pins", 32'(analog_pins), 32'h3);
      check("comp_enable", 32'(comp_enable), 32'h0);
      nrst <= 1'b1;
      rdchk("reset", 8'h19, 8'h00);
      rdchk("reset", 8'h99, 8'h00);
      $display("second reset test done");
      end_of_test();
   end
endmodule : test_cmpref_top
bind cmpref_top cmpref_top_asserts #(.PORT_PINS(PORT_PINS)) u_chk (
   .core_clk(core_clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
   .comp_enable(comp_enable), .vin_minus_switch(vin_minus_switch),
   .ref_to_input(ref_to_input), .reference_enable(reference_enable),
   .reference_range(reference_range), .reference_level(reference_level),
   .reference_tap(reference_tap), .analog_pins(analog_pins),
   .comparator_out_pin_oe(comparator_out_pin_oe),
   .wake_request(wake_request));
`default_nettype wire
